// *** hdl/awr_pkg.sv ***
// constants, register map and types of the alarm waveform recorder
package awr_pkg;
	// ----------------------------------------
	// bus widths
	// ----------------------------------------
	localparam int AW = 8;
	localparam int DW = 32;
	// ----------------------------------------
	// register offsets (byte addresses)
	// ----------------------------------------
	localparam logic [7:0] OFF_CTRL = 8'h00;
	localparam logic [7:0] OFF_START = 8'h04;
	localparam logic [7:0] OFF_TRIG = 8'h08;
	localparam logic [7:0] OFF_CHAN = 8'h0c;
	localparam logic [7:0] OFF_CLR_PARAM = 8'h10;
	localparam logic [7:0] OFF_CLR_OBJ = 8'h14;
	localparam logic [7:0] OFF_STATUS = 8'h18;
	localparam logic [7:0] OFF_INT_STAT = 8'h1c;
	localparam logic [7:0] OFF_INT_MASK = 8'h20;
	localparam logic [7:0] OFF_ALARM_SEL = 8'h24;
	localparam logic [7:0] OFF_TIME = 8'h28;
	localparam logic [7:0] HIST_BASE = 8'h40;
	localparam logic [7:0] HIST_END = 8'hc0;
	// ----------------------------------------
	// fields
	// ----------------------------------------
	localparam int F_MODE = 0;
	localparam int F_SCYC_LO = 8;
	localparam int F_SCYC_HI = 15;
	localparam int F_TRIG_SRC = 0;
	localparam int F_CLR = 0;
	localparam int F_ST_MODE = 2;
	localparam int F_ST_CNT_LO = 4;
	localparam int F_ST_SER_LO = 16;
	localparam int F_H_VALID = 16;
	localparam int F_H_AXIS_LO = 28;
	localparam int INT_REC = 0;
	localparam int INT_REFUSE = 1;
	localparam int INT_CLR = 2;
	localparam int INT_W = 3;
	// ----------------------------------------
	// encodings and reset values
	// ----------------------------------------
	localparam logic MODE_AUTO = 1'b0;
	localparam logic MODE_MANUAL = 1'b1;
	localparam logic [1:0] START_STOP = 2'h0;
	localparam logic [1:0] START_SINGLE = 2'h1;
	localparam logic [1:0] START_CONT = 2'h2;
	localparam logic [7:0] SCYC_RESET = 8'h00;
	localparam logic [3:0] AXIS_DEF = 4'h1;
	// ----------------------------------------
	// history ring
	// ----------------------------------------
	localparam int HIST_DEPTH = 16;
	localparam int IDX_W = 4;
	localparam int CNT_W = 5;
	localparam int SER_W = 14;
	localparam logic [SER_W-1:0] SERIAL_MAX = 14'h270f;
	localparam logic [CNT_W-1:0] CNT_FULL = 5'h10;
	// ----------------------------------------
	// timing
	// ----------------------------------------
	localparam int CLK_PERIOD_PS = 25000;
	localparam int TICK_PERIOD_US = 1000;
	// microseconds to picoseconds before the divide, so one tick is a full millisecond
	localparam int TICK_CYCLES_DEF = TICK_PERIOD_US * 1000 * 1000 / CLK_PERIOD_PS;
	typedef enum logic [1:0] {
		ST_STOP = 2'b00,
		ST_ARMED = 2'b01,
		ST_SAVE = 2'b10
	} awr_state_t;
endpackage : awr_pkg

// *** hdl/awr_hist_if.sv ***
// bundle between recorder control and history ring
`timescale 1ns/1ps
interface awr_hist_if;
	import awr_pkg::*;
	logic push;
	logic clear;
	logic [SER_W-1:0] pushSerial;
	logic [DW-1:0] pushTime;
	logic [IDX_W-1:0] rdIdx;
	logic rdValid;
	logic [SER_W-1:0] rdSerial;
	logic [DW-1:0] rdTime;
	logic [CNT_W-1:0] count;
	modport ring(input push, clear, pushSerial, pushTime, rdIdx,
		output rdValid, rdSerial, rdTime, count);
	modport user(output push, clear, pushSerial, pushTime, rdIdx,
		input rdValid, rdSerial, rdTime, count);
endinterface : awr_hist_if

// *** hdl/awr_history_ring.sv ***
// sixteen-entry history ring, read by age (0 = newest)
`timescale 1ns/1ps
module awr_history_ring import awr_pkg::*; (
	input wire logic clk,
	input wire logic reset_n,
	awr_hist_if.ring hist
);
	logic [IDX_W-1:0] wrPtr;
	logic [CNT_W-1:0] count;
	logic [HIST_DEPTH-1:0] validMem;
	logic [SER_W-1:0] serialMem [HIST_DEPTH];
	logic [DW-1:0] timeMem [HIST_DEPTH];
	logic [IDX_W-1:0] rdSlot;

	// oldest slot is simply rewritten once the ring is full
	always_ff @(posedge clk) begin
		if (!reset_n || hist.clear) begin
			wrPtr <= '0;
			count <= '0;
		end else if (hist.push) begin
			wrPtr <= wrPtr + 4'h1; // see RULE5
			if (count != CNT_FULL) begin
				count <= count + 5'h01;
			end
		end
	end

	for (genvar i = 0; i < HIST_DEPTH; i++) begin : g_entry
		always_ff @(posedge clk) begin
			if (!reset_n || hist.clear) begin
				validMem[i] <= 1'b0; // see RULE9
				serialMem[i] <= '0;
				timeMem[i] <= '0;
			end else if (hist.push && wrPtr == IDX_W'(i)) begin
				validMem[i] <= 1'b1;
				serialMem[i] <= hist.pushSerial;
				timeMem[i] <= hist.pushTime;
			end
		end
	end

	assign rdSlot = wrPtr - 4'h1 - hist.rdIdx; // see RULE4
	assign hist.rdValid = validMem[rdSlot];
	assign hist.rdSerial = serialMem[rdSlot];
	assign hist.rdTime = timeMem[rdSlot];
	assign hist.count = count;
endmodule : awr_history_ring

// *** hdl/awr_recorder.sv ***
// alarm waveform recorder control: modes, triggers, history, registers
//
// Design decisions made here: the strobed register port and the address map.
`timescale 1ns/1ps
// Functional notes
// RULE1 - reset comes up in automatic mode
// RULE2 - alarm capture is saved into history
// RULE3 - status register shows recorder state
// RULE4 - sixteen history entries, newest first, with time
// RULE5 - keep sixteen, overwrite the oldest
// RULE6 - serial counts up, wraps after 9999
// RULE7 - record name holds axis number from one
// RULE8 - serial equals reported history index
// RULE9 - either clear register erases history
// RULE10 - mode one selects manual capture
// RULE11 - start one single, two continuous
// RULE12 - start zero stops sampling
// RULE13 - capture settings locked while sampling
// RULE14 - mode zero returns to automatic
// RULE15 - software minds storage write endurance
// RULE16 - automatic mode ignores manual settings
// RULE17 - triggers ignored until save completes
// RULE18 - single capture ends in stopped state
module awr_recorder import awr_pkg::*; #(
	parameter int TICK_CYCLES = TICK_CYCLES_DEF,
	parameter logic [3:0] AXIS_NUM = AXIS_DEF
) (
	input wire logic clk,
	input wire logic reset_n,
	input wire logic [AW-1:0] regAddr,
	input wire logic [DW-1:0] regWrData,
	input wire logic regWr,
	input wire logic regRd,
	output logic [DW-1:0] regRdData,
	input wire logic alarmTrig,
	input wire logic [7:0] alarmCode,
	input wire logic condTrig,
	input wire logic saveDone,
	output logic capture,
	output logic saveReq,
	output logic recorderModeSelect,
	output logic [7:0] sampleCycleSelect,
	output logic [DW-1:0] triggerConfig,
	output logic [DW-1:0] channelConfig,
	output logic irq
);
	// ----------------------------------------
	// declarations
	// ----------------------------------------
	awr_state_t state;
	awr_state_t next_state;
	logic [1:0] samplingStartSelect;
	logic [1:0] next_start;
	logic [7:0] desiredAlarmTrigger;
	logic [SER_W-1:0] serial;
	logic [INT_W-1:0] intStat;
	logic [INT_W-1:0] intMask;
	logic [INT_W-1:0] intEvent;
	logic [15:0] tickCnt;
	logic [DW-1:0] timeNow;
	logic [DW-1:0] next_rdData;
	logic wrCtrl;
	logic wrStart;
	logic wrTrig;
	logic wrChan;
	logic wrClrParam;
	logic wrClrObj;
	logic wrIntStat;
	logic wrIntMask;
	logic wrAlarmSel;
	logic running;
	logic cfgRefused;
	logic histClear;
	logic alarmHit;
	logic trigHit;
	logic saveEnd;
	logic singleEnd;
	logic tickEnd;
	logic histSel;
	logic [7:0] histOff;
	logic [DW-1:0] histWord0;
	logic [DW-1:0] statusWord;

	awr_hist_if hist();

	awr_history_ring u_ring (
		.clk(clk),
		.reset_n(reset_n),
		.hist(hist)
	);

	// ----------------------------------------
	// write decode
	// ----------------------------------------
	assign wrCtrl = regWr && (regAddr == OFF_CTRL);
	assign wrStart = regWr && (regAddr == OFF_START);
	assign wrTrig = regWr && (regAddr == OFF_TRIG);
	assign wrChan = regWr && (regAddr == OFF_CHAN);
	assign wrClrParam = regWr && (regAddr == OFF_CLR_PARAM);
	assign wrClrObj = regWr && (regAddr == OFF_CLR_OBJ);
	assign wrIntStat = regWr && (regAddr == OFF_INT_STAT);
	assign wrIntMask = regWr && (regAddr == OFF_INT_MASK);
	assign wrAlarmSel = regWr && (regAddr == OFF_ALARM_SEL);

	// ----------------------------------------
	// capture control
	// ----------------------------------------
	// manual sampling counts as running until stopped again
	assign running = (recorderModeSelect == MODE_MANUAL)
		&& (state != ST_STOP);

	// a sampling-cycle write in the mode register is dropped, the mode bit kept
	assign cfgRefused = running && (wrTrig || wrChan
		|| (wrCtrl && regWrData[F_SCYC_HI:F_SCYC_LO] != sampleCycleSelect));

	assign histClear = (wrClrParam || wrClrObj) && regWrData[F_CLR]; // see RULE9

	// zero selects every alarm, otherwise only the chosen code
	assign alarmHit = alarmTrig
		&& (desiredAlarmTrigger == 8'h00 || desiredAlarmTrigger == alarmCode);

	// automatic mode looks at alarms only
	assign trigHit = (recorderModeSelect == MODE_AUTO) ? alarmHit // see RULE16
		: (triggerConfig[F_TRIG_SRC] ? condTrig : alarmHit);

	assign saveEnd = (state == ST_SAVE) && saveDone;

	assign singleEnd = saveEnd && (recorderModeSelect == MODE_MANUAL)
		&& (samplingStartSelect != START_CONT);

	always_comb begin
		next_state = state;
		case (state)
			ST_STOP: begin
				if (recorderModeSelect == MODE_AUTO) begin
					next_state = ST_ARMED; // see RULE14
				end else if (samplingStartSelect == START_SINGLE
					|| samplingStartSelect == START_CONT) begin
					next_state = ST_ARMED; // see RULE11
				end
			end
			ST_ARMED: begin
				if (recorderModeSelect == MODE_MANUAL
					&& samplingStartSelect == START_STOP) begin
					next_state = ST_STOP; // see RULE12
				end else if (trigHit) begin
					next_state = ST_SAVE; // see RULE2
				end
			end
			ST_SAVE: begin
				// further triggers fall on the floor here
				if (singleEnd || (saveDone && samplingStartSelect == START_STOP
					&& recorderModeSelect == MODE_MANUAL)) begin
					next_state = ST_STOP; // see RULE18
				end else if (saveDone) begin
					next_state = ST_ARMED; // see RULE17
				end
			end
			default: begin
				next_state = ST_STOP;
			end
		endcase
	end

	// a software write of 0, 1 or 2 to the start field wins over the auto-stop
	always_comb begin
		next_start = samplingStartSelect;
		if (wrStart && regWrData[1:0] != 2'h3) begin
			next_start = regWrData[1:0];
		end else if (singleEnd) begin
			next_start = START_STOP; // see RULE18
		end
	end

	always_ff @(posedge clk) begin
		if (!reset_n) begin
			state <= ST_STOP;
			samplingStartSelect <= START_STOP;
		end else begin
			state <= next_state;
			samplingStartSelect <= next_start;
		end
	end

	always_ff @(posedge clk) begin
		if (!reset_n) begin
			capture <= 1'b0;
			saveReq <= 1'b0;
		end else begin
			capture <= (next_state == ST_ARMED);
			saveReq <= (next_state == ST_SAVE);
		end
	end

	// ----------------------------------------
	// configuration registers
	// ----------------------------------------
	always_ff @(posedge clk) begin
		if (!reset_n) begin
			recorderModeSelect <= MODE_AUTO; // see RULE1
		end else if (wrCtrl) begin
			recorderModeSelect <= regWrData[F_MODE]; // see RULE10
		end
	end

	always_ff @(posedge clk) begin
		if (!reset_n) begin
			sampleCycleSelect <= SCYC_RESET;
		end else if (wrCtrl && !running) begin
			sampleCycleSelect <= regWrData[F_SCYC_HI:F_SCYC_LO]; // see RULE13
		end
	end

	always_ff @(posedge clk) begin
		if (!reset_n) begin
			triggerConfig <= '0;
		end else if (wrTrig && !running) begin
			triggerConfig <= regWrData; // see RULE13
		end
	end

	always_ff @(posedge clk) begin
		if (!reset_n) begin
			channelConfig <= '0;
		end else if (wrChan && !running) begin
			channelConfig <= regWrData; // see RULE13
		end
	end

	always_ff @(posedge clk) begin
		if (!reset_n) begin
			desiredAlarmTrigger <= 8'h00;
		end else if (wrAlarmSel) begin
			desiredAlarmTrigger <= regWrData[7:0];
		end
	end

	// ----------------------------------------
	// record time base
	// ----------------------------------------
	assign tickEnd = (tickCnt == 16'(TICK_CYCLES - 1));

	always_ff @(posedge clk) begin
		if (!reset_n || tickEnd) begin
			tickCnt <= '0;
		end else begin
			tickCnt <= tickCnt + 16'h0001;
		end
	end

	always_ff @(posedge clk) begin
		if (!reset_n) begin
			timeNow <= '0;
		end else if (tickEnd) begin
			timeNow <= timeNow + 32'h0000_0001;
		end
	end

	// ----------------------------------------
	// history and serial number
	// ----------------------------------------
	// serial keeps counting across clears so file names stay unique
	always_ff @(posedge clk) begin
		if (!reset_n) begin
			serial <= '0;
		end else if (saveEnd) begin
			if (serial == SERIAL_MAX) begin
				serial <= '0; // see RULE6
			end else begin
				serial <= serial + 14'h0001; // see RULE6
			end
		end
	end

	assign hist.push = saveEnd; // see RULE5
	assign hist.clear = histClear;
	assign hist.pushSerial = serial; // see RULE8
	assign hist.pushTime = timeNow; // see RULE4

	assign histSel = (regAddr >= HIST_BASE) && (regAddr < HIST_END);
	assign histOff = regAddr - HIST_BASE;
	assign hist.rdIdx = histOff[6:3];

	assign histWord0 = {AXIS_NUM, 11'h000, hist.rdValid, 2'h0, // see RULE7
		hist.rdSerial}; // see RULE8

	assign statusWord = {2'h0, serial, 7'h00, hist.count, // see RULE3
		1'b0, recorderModeSelect, state};

	// ----------------------------------------
	// interrupts
	// ----------------------------------------
	assign intEvent = {histClear, cfgRefused, saveEnd};

	// new events outrank a same-cycle write-one clear
	always_ff @(posedge clk) begin
		if (!reset_n) begin
			intStat <= '0;
		end else if (wrIntStat) begin
			intStat <= (intStat & ~regWrData[INT_W-1:0]) | intEvent;
		end else begin
			intStat <= intStat | intEvent;
		end
	end

	always_ff @(posedge clk) begin
		if (!reset_n) begin
			intMask <= '0;
		end else if (wrIntMask) begin
			intMask <= regWrData[INT_W-1:0];
		end
	end

	always_ff @(posedge clk) begin
		if (!reset_n) begin
			irq <= 1'b0;
		end else begin
			irq <= |(intStat & intMask);
		end
	end

	// ----------------------------------------
	// read path
	// ----------------------------------------
	always_comb begin
		next_rdData = '0;
		if (!regRd) begin
			next_rdData = '0;
		end else if (regAddr == OFF_CTRL) begin
			next_rdData[F_MODE] = recorderModeSelect;
			next_rdData[F_SCYC_HI:F_SCYC_LO] = sampleCycleSelect;
		end else if (regAddr == OFF_START) begin
			next_rdData[1:0] = samplingStartSelect;
		end else if (regAddr == OFF_TRIG) begin
			next_rdData = triggerConfig;
		end else if (regAddr == OFF_CHAN) begin
			next_rdData = channelConfig;
		end else if (regAddr == OFF_STATUS) begin
			next_rdData = statusWord;
		end else if (regAddr == OFF_INT_STAT) begin
			next_rdData[INT_W-1:0] = intStat;
		end else if (regAddr == OFF_INT_MASK) begin
			next_rdData[INT_W-1:0] = intMask;
		end else if (regAddr == OFF_ALARM_SEL) begin
			next_rdData[7:0] = desiredAlarmTrigger;
		end else if (regAddr == OFF_TIME) begin
			next_rdData = timeNow;
		end else if (histSel && !histOff[2]) begin
			next_rdData = histWord0;
		end else if (histSel) begin
			next_rdData = hist.rdTime;
		end
	end

	// data stands for exactly the cycle after the read strobe
	always_ff @(posedge clk) begin
		if (!reset_n) begin
			regRdData <= '0;
		end else begin
			regRdData <= next_rdData;
		end
	end
endmodule : awr_recorder

// *** hdl/awr_fix.sv ***
// spare file, holds no logic

// *** testbench/awr_recorder_props.sv ***
// port-level assertions for the alarm waveform recorder
`timescale 1ns/1ps
module awr_recorder_props import awr_pkg::*; #(
	parameter int TICK_CYCLES = TICK_CYCLES_DEF,
	parameter logic [3:0] AXIS_NUM = AXIS_DEF
) (
	input wire logic clk,
	input wire logic reset_n,
	input wire logic [AW-1:0] regAddr,
	input wire logic [DW-1:0] regWrData,
	input wire logic regWr,
	input wire logic regRd,
	input wire logic [DW-1:0] regRdData,
	input wire logic alarmTrig,
	input wire logic [7:0] alarmCode,
	input wire logic condTrig,
	input wire logic saveDone,
	input wire logic capture,
	input wire logic saveReq,
	input wire logic recorderModeSelect,
	input wire logic [7:0] sampleCycleSelect,
	input wire logic [DW-1:0] triggerConfig,
	input wire logic [DW-1:0] channelConfig,
	input wire logic irq
);
	default clocking @(posedge clk); endclocking
	default disable iff (!reset_n);
	sequence saveEnd;
		saveReq && saveDone;
	endsequence
	sequence running;
		recorderModeSelect && (capture || saveReq);
	endsequence
	sequence startWrite;
		regWr && regAddr == OFF_START;
	endsequence
	property modeFollows;
		regWr && regAddr == OFF_CTRL |=> recorderModeSelect == $past(regWrData[F_MODE]);
	endproperty
	a_reset_auto: assert property ($rose(reset_n) |-> !recorderModeSelect ##1 capture)
		else $error("recorder not armed in automatic mode after reset");
	a_trig_cause: assert property ($rose(saveReq) |-> $past(capture))
		else $error("save started without an armed trigger");
	a_save_hold: assert property (saveReq && !saveDone |=> saveReq && !capture)
		else $error("save dropped or rearmed before completion");
	a_save_end: assert property (saveEnd |=> !saveReq)
		else $error("save request stayed after completion");
	a_auto_rearm: assert property (saveEnd |=> capture || recorderModeSelect)
		else $error("automatic mode did not rearm after save");
	a_auto_cond: assert property (capture && !recorderModeSelect && !alarmTrig |=> !saveReq)
		else $error("automatic mode captured without alarm");
	a_cfg_locked: assert property (running |=> $stable(triggerConfig) && $stable(channelConfig)
		&& $stable(sampleCycleSelect))
		else $error("capture settings changed while sampling");
	a_start_arms: assert property (startWrite ##0 (recorderModeSelect && !capture && !saveReq
		&& regWrData[1:0] != START_STOP && regWrData[1:0] != 2'h3) |-> ##[1:2] capture)
		else $error("start write did not arm capture");
	a_stop_halts: assert property (startWrite ##0 (regWrData[1:0] == START_STOP
		&& recorderModeSelect) |-> ##[1:2] !capture)
		else $error("stop write left capture armed");
	a_mode_write: assert property (modeFollows)
		else $error("mode output does not follow control write");
	a_read_idle: assert property (!regRd |=> regRdData == '0)
		else $error("read data present without a read");
endmodule : awr_recorder_props
bind awr_recorder awr_recorder_props #(.TICK_CYCLES(TICK_CYCLES), .AXIS_NUM(AXIS_NUM))
	awr_recorder_props_inst (.clk(clk), .reset_n(reset_n), .regAddr(regAddr),
	.regWrData(regWrData), .regWr(regWr), .regRd(regRd), .regRdData(regRdData),
	.alarmTrig(alarmTrig), .alarmCode(alarmCode), .condTrig(condTrig), .saveDone(saveDone),
	.capture(capture), .saveReq(saveReq), .recorderModeSelect(recorderModeSelect),
	.sampleCycleSelect(sampleCycleSelect), .triggerConfig(triggerConfig),
	.channelConfig(channelConfig), .irq(irq));

// *** testbench/awr_recorder_tb.sv ***
// self-checking bench for the alarm waveform recorder
`timescale 1ns/1ps
module awr_recorder_tb import awr_pkg::*;;
	logic clk = 1'b0;
	logic reset_n = 1'b0;
	logic [AW-1:0] regAddr = '0;
	logic [DW-1:0] regWrData = '0;
	logic regWr = 1'b0;
	logic regRd = 1'b0;
	logic alarmTrig = 1'b0;
	logic condTrig = 1'b0;
	logic saveDone = 1'b0;
	logic [7:0] alarmCode = 8'h21;
	logic [DW-1:0] regRdData, triggerConfig, channelConfig;
	logic capture, saveReq, recorderModeSelect, irq;
	logic [7:0] sampleCycleSelect;
	logic [SER_W-1:0] ser = '0;
	int nFail = 0;
	int checkCount = 0;
	always #12.5 clk = ~clk;
	awr_recorder #(.TICK_CYCLES(4)) awr_recorder_inst (.clk(clk), .reset_n(reset_n),
		.regAddr(regAddr), .regWrData(regWrData), .regWr(regWr), .regRd(regRd),
		.regRdData(regRdData), .alarmTrig(alarmTrig), .alarmCode(alarmCode), .condTrig(condTrig),
		.saveDone(saveDone), .capture(capture), .saveReq(saveReq),
		.recorderModeSelect(recorderModeSelect), .sampleCycleSelect(sampleCycleSelect),
		.triggerConfig(triggerConfig), .channelConfig(channelConfig), .irq(irq));
	// ----------------------------------------
	// shared tasks
	// ----------------------------------------
	task automatic complete_run();
		$display("comparisons %0d, mismatches %0d", checkCount, nFail);
		if (nFail == 0 && checkCount > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask : complete_run
	task automatic chk(input logic [DW-1:0] got, input logic [DW-1:0] exp);
		checkCount++;
		if (got !== exp) begin
			nFail++;
			$display("MISMATCH at %0t: got %h expected %h", $time, got, exp);
		end
	endtask : chk
	task automatic wr(input logic [AW-1:0] a, input logic [DW-1:0] d);
		@(posedge clk);
		regAddr <= a;
		regWrData <= d;
		regWr <= 1'b1;
		@(posedge clk);
		regWr <= 1'b0;
	endtask : wr
	task automatic rdchk(input logic [AW-1:0] a, input logic [DW-1:0] m, input logic [DW-1:0] e);
		@(posedge clk);
		regAddr <= a;
		regRd <= 1'b1;
		@(posedge clk);
		regRd <= 1'b0;
		#1 chk(regRdData & m, e);
	endtask : rdchk
	task automatic wait_save(input logic lvl);
		int n;
		n = 0;
		#1;
		while (saveReq !== lvl) begin
			@(posedge clk);
			#1 n++;
			if (n > 20) begin
				nFail++;
				complete_run();
			end
		end
	endtask : wait_save
	// stray triggers ride on the save cycle: they must not start a second capture
	task automatic cap(input logic useCond);
		@(posedge clk);
		alarmTrig <= !useCond;
		condTrig <= useCond;
		@(posedge clk);
		alarmTrig <= 1'b0;
		condTrig <= 1'b0;
		wait_save(1'b1);
		@(posedge clk);
		saveDone <= 1'b1;
		alarmTrig <= 1'b1;
		condTrig <= 1'b1;
		@(posedge clk);
		saveDone <= 1'b0;
		alarmTrig <= 1'b0;
		condTrig <= 1'b0;
		wait_save(1'b0);
		ser = (ser == 14'h270f) ? '0 : ser + 14'h1;
	endtask : cap
	task automatic chk_status(input logic [4:0] cnt);
		rdchk(OFF_STATUS, 32'h3fff_01f0, {2'h0, ser, 7'h0, cnt, 4'h0});
	endtask : chk_status
	// ----------------------------------------
	// scenarios
	// ----------------------------------------
	task automatic t_reset_irq();
		rdchk(OFF_STATUS, 32'h3fff_01f7, 32'h1);
		chk(capture, 1'b1);
		rdchk(8'hfc, 32'hffff_ffff, 32'h0);
		wr(OFF_INT_MASK, 32'h1);
		cap(1'b0);
		rdchk(OFF_INT_STAT, 32'h7, 32'h1);
		chk(irq, 1'b1);
		wr(OFF_INT_STAT, 32'h1);
		rdchk(OFF_INT_STAT, 32'h7, 32'h0);
		chk(irq, 1'b0);
		wr(OFF_INT_MASK, 32'h0);
		cap(1'b0);
		rdchk(OFF_INT_STAT, 32'h1, 32'h1);
		chk(irq, 1'b0);
		wr(OFF_INT_STAT, 32'h7);
		$display("test reset_irq done");
	endtask : t_reset_irq
	task automatic t_ring();
		logic [DW-1:0] tNew;
		repeat (16) cap(1'b0);
		chk_status(5'h10);
		for (int k = 0; k < 16; k++) begin
			rdchk(HIST_BASE + 8'(8 * k), 32'hf001_3fff,
				{AXIS_DEF, 11'h0, 1'b1, 2'h0, ser - 14'(k + 1)});
		end
		rdchk(HIST_BASE + 8'h04, 32'h0, 32'h0);
		tNew = regRdData;
		rdchk(HIST_BASE + 8'h7c, 32'h0, 32'h0);
		chk({31'h0, tNew > regRdData}, 32'h1);
		$display("test ring done");
	endtask : t_ring
	task automatic t_wrap();
		while (ser != '0)
			cap(1'b0);
		chk_status(5'h10);
		rdchk(HIST_BASE, 32'h0000_3fff, 32'h0000_270f);
		$display("test wrap done");
	endtask : t_wrap
	task automatic t_clear();
		logic [AW-1:0] offs [2];
		offs = '{OFF_CLR_PARAM, OFF_CLR_OBJ};
		foreach (offs[i]) begin
			cap(1'b0);
			wr(offs[i], 32'h1);
			chk_status(5'h0);
			rdchk(HIST_BASE, 32'h0001_0000, 32'h0);
		end
		rdchk(OFF_INT_STAT, 32'h4, 32'h4);
		$display("test clear done");
	endtask : t_clear
	task automatic t_manual();
		wr(OFF_CTRL, 32'h0000_0701);
		rdchk(OFF_STATUS, 32'h7, 32'h4);
		chk(sampleCycleSelect, 32'h07);
		wr(OFF_TRIG, 32'h1);
		wr(OFF_CHAN, 32'ha5);
		wr(OFF_START, 32'h1);
		rdchk(OFF_STATUS, 32'h7, 32'h5);
		cap(1'b1);
		rdchk(OFF_START, 32'h3, 32'h0);
		chk(capture, 1'b0);
		wr(OFF_START, 32'h2);
		cap(1'b1);
		cap(1'b1);
		rdchk(OFF_STATUS, 32'h3, 32'h1);
		wr(OFF_TRIG, 32'h0);
		wr(OFF_CTRL, 32'h0000_0901);
		rdchk(OFF_INT_STAT, 32'h2, 32'h2);
		chk(triggerConfig, 32'h1);
		chk(sampleCycleSelect, 32'h07);
		wr(OFF_START, 32'h0);
		rdchk(OFF_STATUS, 32'h3, 32'h0);
		wr(OFF_TRIG, 32'h0);
		rdchk(OFF_CHAN, 32'hffff_ffff, 32'ha5);
		chk(triggerConfig, 32'h0);
		chk(channelConfig, 32'ha5);
		// leave the condition source selected so automatic mode has something to ignore
		wr(OFF_TRIG, 32'h1);
		wr(OFF_CTRL, 32'h0);
		rdchk(OFF_STATUS, 32'h7, 32'h1);
		wr(OFF_ALARM_SEL, 32'h33);
		@(posedge clk);
		condTrig <= 1'b1;
		alarmTrig <= 1'b1;
		@(posedge clk);
		condTrig <= 1'b0;
		alarmTrig <= 1'b0;
		rdchk(OFF_STATUS, 32'h3, 32'h1);
		alarmCode <= 8'h33;
		cap(1'b0);
		chk_status(5'h4);
		$display("test manual done");
	endtask : t_manual
	initial begin
		repeat (8) @(posedge clk);
		reset_n <= 1'b1;
		t_reset_irq();
		t_ring();
		t_wrap();
		t_clear();
		t_manual();
		complete_run();
	end
endmodule : awr_recorder_tb
